/* pkg/twi_sr_pkg.sv */
// ************************************************************
// Constants of the two-wire slave receiver.
// ************************************************************
package twi_sr_pkg;

   // ************************************************************
   // Register byte addresses on the APB.
   // ************************************************************
   localparam logic [7:0] ADDR_OWN = 8'h00;
   localparam logic [7:0] ADDR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_DATA = 8'h0C;

   // ************************************************************
   // Bit positions in the serial control register.
   // ************************************************************
   localparam int CTL_FLAG = 7;
   localparam int CTL_ACK = 6;
   localparam int CTL_STA = 5;
   localparam int CTL_STO = 4;
   localparam int CTL_WC = 3;
   localparam int CTL_EN = 2;
   localparam int CTL_IE = 0;

   // Control bits that software may write directly.
   localparam logic [7:0] CTL_WMASK = 8'h75;

   // ************************************************************
   // Reset values and field constants.
   // ************************************************************
   localparam logic [7:0] OWN_RESET = 8'h00;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [6:0] GC_ADDR = 7'h00;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [7:0] PRESC_MASK = 8'hF8;

   // ************************************************************
   // Status codes reported after each bus event.
   // ************************************************************
   localparam logic [7:0] STS_OWN_W = 8'h60;
   localparam logic [7:0] STS_ARB_OWN_W = 8'h68;
   localparam logic [7:0] STS_GC = 8'h70;
   localparam logic [7:0] STS_ARB_GC = 8'h78;
   localparam logic [7:0] STS_DATA_ACK = 8'h80;
   localparam logic [7:0] STS_DATA_NACK = 8'h88;
   localparam logic [7:0] STS_GC_ACK = 8'h90;
   localparam logic [7:0] STS_GC_NACK = 8'h98;
   localparam logic [7:0] STS_STOP = 8'hA0;
   localparam logic [7:0] STS_IDLE = 8'hF8;

   // Phases of the slave receiver.
   typedef enum {
      PH_IDLE, PH_ADDR, PH_ACK, PH_HOLD, PH_DATA, PH_SKIP
   } phase_t;

endpackage : twi_sr_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
// ************************************************************
// Two-flop synchroniser for the bus pins.
// ************************************************************
module pin_sync (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Raw pins and their synchronised copies.
   input wire logic [1:0] pin_i,
   output logic [1:0] pin_o
);

   logic [1:0] meta_q;
   logic [1:0] sync_q;

   // Each pin passes two flops; only the second stage is read.
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               meta_q[g] <= 1'b1;
               sync_q[g] <= 1'b1;
            end else begin
               meta_q[g] <= pin_i[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   assign pin_o = sync_q;

endmodule : pin_sync

/* rtl/bus_watch.sv */
`timescale 1ns/1ps
// ************************************************************
// Bus event detector: clock edges, START and STOP.
// ************************************************************
module bus_watch (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Synchronised bus lines.
   input wire logic scl_i,
   input wire logic sda_i,
   // One-cycle event pulses.
   output logic rise_o,
   output logic fall_o,
   output logic start_o,
   output logic stop_o
);

   logic scl_q;
   logic sda_q;

   // Previous line levels, for edge detection.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   // A data edge while the clock stays high is START or STOP.
   assign rise_o = scl_i && !scl_q;
   assign fall_o = !scl_i && scl_q;
   assign start_o = scl_i && scl_q && sda_q && !sda_i;
   assign stop_o = scl_i && scl_q && !sda_q && sda_i;

endmodule : bus_watch

/* rtl/twi_slave_receiver.sv */
`timescale 1ns/1ps
// What this block does
// - Upper seven address bits form own address.
// - Address bit zero enables general call.
// - Acknowledge only when enabled and ack enabled.
// - Write bit enters receive, read enters transmit.
// - Address with write sets flag and status.
// - Arbitration loss then addressed reports 0x68/0x78.
// - Cleared ack enable gives NACK next byte.
// - Ack enable zero isolates; setting it resumes.
// - Deep sleep match wakes part, holds clock.
// - Writing one clears flag, releasing clock.
// - Data register may be stale after wake.
// - Own address acked gives 0x60.
// - Arbitration lost then own address gives 0x68.
// - General call acked gives 0x70.
// - Arbitration lost then general call gives 0x78.
// - Acked own data gives 0x80, readable.
// - Nacked own data gives 0x88, then unaddressed.
// - Unaddressed mode recognises per ack and enables.
// - General call data gives 0x90 or 0x98.
// - STOP or repeated START while addressed: 0xA0.
module twi_slave_receiver (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // APB register port.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Two-wire bus pins.
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Neighbouring logic of the part.
   input wire logic arb_lost_i,
   input wire logic deep_sleep_i,
   output logic wake_o,
   output logic slave_transmit_mode_o,
   output logic start_pending_o
);

   // ************************************************************
   // State of the block.
   // ************************************************************
   typedef struct packed {
      twi_sr_pkg::phase_t ph;
      logic [7:0] own_slave_address;
      logic [7:0] serial_control;
      logic [7:0] serial_status_reg;
      logic [7:0] serial_data_reg;
      logic [7:0] shift;
      logic [7:0] code;
      logic [2:0] cnt;
      logic got8;
      logic gc;
      logic addressed;
      logic arb;
      logic ack_next;
      logic nack_end;
      logic slave_tx;
      logic wake;
      logic busy;
      logic start_pend;
      logic scl_oe;
      logic sda_oe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_t;

   state_t q;
   state_t d;

   logic [1:0] pins_sync;
   logic rise;
   logic fall;
   logic start_ev;
   logic stop_ev;

   // ************************************************************
   // Pin synchronisation and bus event detection.
   // ************************************************************
   pin_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i({scl_i, sda_i}),
      .pin_o(pins_sync)
   );

   bus_watch u_watch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .scl_i(pins_sync[1]),
      .sda_i(pins_sync[0]),
      .rise_o(rise),
      .fall_o(fall),
      .start_o(start_ev),
      .stop_o(stop_ev)
   );

   // Register hit test, shared by the read and write paths.
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == twi_sr_pkg::ADDR_OWN) ||
                (a == twi_sr_pkg::ADDR_CTRL) ||
                (a == twi_sr_pkg::ADDR_STAT) ||
                (a == twi_sr_pkg::ADDR_DATA);
   endfunction : reg_hit

   // ************************************************************
   // Next-state logic.
   // ************************************************************
   always_comb begin
      logic wr;
      logic fclr;
      logic en;
      logic ack;
      logic own_hit;
      logic gc_hit;
      logic recog;
      d = q;
      wr = 1'b0;
      fclr = 1'b0;
      en = q.serial_control[twi_sr_pkg::CTL_EN];
      ack = q.serial_control[twi_sr_pkg::CTL_ACK];
      own_hit = 1'b0;
      gc_hit = 1'b0;
      recog = 1'b0;
      d.pready = 1'b0;
      d.pslverr = 1'b0;

      // Setup phase: prepare read data and answer in the next cycle.
      if (psel_i && !penable_i) begin
         d.pready = 1'b1;
         d.pslverr = !reg_hit(paddr_i);
         d.prdata = 32'h0000_0000;
         case (paddr_i)
            twi_sr_pkg::ADDR_OWN:
               d.prdata[7:0] = q.own_slave_address;
            twi_sr_pkg::ADDR_CTRL:
               d.prdata[7:0] = q.serial_control;
            twi_sr_pkg::ADDR_STAT:
               d.prdata[7:0] = q.serial_status_reg &
                               twi_sr_pkg::PRESC_MASK;
            twi_sr_pkg::ADDR_DATA:
               d.prdata[7:0] = q.serial_data_reg;
            default:
               d.prdata = 32'h0000_0000;
         endcase
      end

      // Access phase: a write takes effect on the pready edge.
      wr = psel_i && penable_i && pwrite_i && q.pready && !q.pslverr;
      if (wr) begin
         case (paddr_i)
            twi_sr_pkg::ADDR_OWN:
               d.own_slave_address = pwdata_i[7:0];
            twi_sr_pkg::ADDR_CTRL: begin
               d.serial_control =
                  (q.serial_control & ~twi_sr_pkg::CTL_WMASK) |
                  (pwdata_i[7:0] & twi_sr_pkg::CTL_WMASK);
               if (pwdata_i[twi_sr_pkg::CTL_FLAG]) begin
                  d.serial_control[twi_sr_pkg::CTL_FLAG] = 1'b0;
                  fclr = q.serial_control[twi_sr_pkg::CTL_FLAG];
               end
            end
            twi_sr_pkg::ADDR_DATA: begin
               d.serial_data_reg = pwdata_i[7:0];
               d.serial_control[twi_sr_pkg::CTL_WC] =
                  !q.serial_control[twi_sr_pkg::CTL_FLAG];
            end
            default: begin
            end
         endcase
      end

      // Arbitration loss from the master side is remembered.
      if (arb_lost_i) begin
         d.arb = 1'b1;
      end

      // Bus busy between START and STOP.
      if (start_ev) begin
         d.busy = 1'b1;
      end else if (stop_ev) begin
         d.busy = 1'b0;
      end

      // ************************************************************
      // Bus protocol; hardware flag sets come after software clears.
      // ************************************************************
      if (!en) begin
         d.ph = twi_sr_pkg::PH_IDLE;
         d.scl_oe = 1'b0;
         d.sda_oe = 1'b0;
         d.addressed = 1'b0;
         d.wake = 1'b0;
      end else if ((start_ev || stop_ev) && q.ph != twi_sr_pkg::PH_HOLD) begin
         if (q.addressed) begin
            d.serial_control[twi_sr_pkg::CTL_FLAG] = 1'b1;
            d.serial_status_reg = twi_sr_pkg::STS_STOP;
            d.addressed = 1'b0;
         end
         d.sda_oe = 1'b0;
         d.slave_tx = 1'b0;
         d.cnt = 3'h0;
         d.got8 = 1'b0;
         d.ph = start_ev ? twi_sr_pkg::PH_ADDR : twi_sr_pkg::PH_IDLE;
      end else begin
         case (q.ph)
            twi_sr_pkg::PH_ADDR, twi_sr_pkg::PH_DATA: begin
               // Sample one bit on each rising clock edge.
               if (rise) begin
                  d.shift = {q.shift[6:0], pins_sync[0]};
                  d.cnt = q.cnt + 3'h1;
                  d.got8 = (q.cnt == twi_sr_pkg::LAST_BIT);
               end
               if (fall && q.got8) begin
                  d.got8 = 1'b0;
                  if (q.ph == twi_sr_pkg::PH_ADDR) begin
                     own_hit = q.shift[7:1] ==
                               q.own_slave_address[7:1];
                     gc_hit = (q.shift[7:1] == twi_sr_pkg::GC_ADDR) &&
                              q.own_slave_address[0];
                     recog = ack && (own_hit || gc_hit);
                     if (recog && !q.shift[0]) begin
                        d.ph = twi_sr_pkg::PH_ACK;
                        d.sda_oe = 1'b1;
                        d.addressed = 1'b1;
                        d.nack_end = 1'b0;
                        d.gc = gc_hit && !own_hit;
                        if (gc_hit && !own_hit) begin
                           d.code = q.arb ? twi_sr_pkg::STS_ARB_GC
                                          : twi_sr_pkg::STS_GC;
                        end else begin
                           d.code = q.arb ? twi_sr_pkg::STS_ARB_OWN_W
                                          : twi_sr_pkg::STS_OWN_W;
                        end
                        d.arb = 1'b0;
                        d.wake = deep_sleep_i;
                     end else if (recog) begin
                        d.slave_tx = 1'b1;
                        d.ph = twi_sr_pkg::PH_SKIP;
                     end else begin
                        d.ph = twi_sr_pkg::PH_SKIP;
                     end
                  end else begin
                     // The byte is readable once the flag is raised.
                     d.serial_data_reg = q.shift;
                     d.sda_oe = q.ack_next;
                     d.nack_end = !q.ack_next;
                     d.ph = twi_sr_pkg::PH_ACK;
                     if (q.gc) begin
                        d.code = q.ack_next ? twi_sr_pkg::STS_GC_ACK
                                            : twi_sr_pkg::STS_GC_NACK;
                     end else begin
                        d.code = q.ack_next ? twi_sr_pkg::STS_DATA_ACK
                                            : twi_sr_pkg::STS_DATA_NACK;
                     end
                  end
               end
            end
            twi_sr_pkg::PH_ACK: begin
               // End of the acknowledge clock: report and stretch.
               if (fall) begin
                  d.sda_oe = 1'b0;
                  d.serial_control[twi_sr_pkg::CTL_FLAG] = 1'b1;
                  d.serial_status_reg = q.code;
                  d.scl_oe = 1'b1;
                  d.ph = twi_sr_pkg::PH_HOLD;
               end
            end
            twi_sr_pkg::PH_HOLD: begin
               // The clock stays low until software clears the flag.
               if (fclr) begin
                  d.scl_oe = 1'b0;
                  d.wake = 1'b0;
                  d.serial_status_reg = twi_sr_pkg::STS_IDLE;
                  d.ack_next = d.serial_control[twi_sr_pkg::CTL_ACK];
                  d.cnt = 3'h0;
                  if (q.nack_end) begin
                     d.addressed = 1'b0;
                     d.nack_end = 1'b0;
                     d.ph = twi_sr_pkg::PH_SKIP;
                  end else begin
                     d.ph = twi_sr_pkg::PH_DATA;
                  end
               end
            end
            twi_sr_pkg::PH_IDLE, twi_sr_pkg::PH_SKIP: begin
               // Not addressed: only START and STOP are watched.
               d.sda_oe = 1'b0;
            end
            default: begin
               d.ph = twi_sr_pkg::PH_IDLE;
            end
         endcase
      end

      // Clearing the flag returns the status to idle; a new report wins.
      if (fclr && q.ph != twi_sr_pkg::PH_HOLD &&
          !d.serial_control[twi_sr_pkg::CTL_FLAG]) begin
         d.serial_status_reg = twi_sr_pkg::STS_IDLE;
      end

      // A queued START waits for a free bus.
      d.start_pend = d.serial_control[twi_sr_pkg::CTL_STA] &&
                     en && !d.busy;
   end

   // ************************************************************
   // State register.
   // ************************************************************
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
         q.ph <= twi_sr_pkg::PH_IDLE;
         q.own_slave_address <= twi_sr_pkg::OWN_RESET;
         q.serial_control <= twi_sr_pkg::CTL_RESET;
         q.serial_status_reg <= twi_sr_pkg::STS_IDLE;
         q.serial_data_reg <= twi_sr_pkg::DATA_RESET;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // Outputs from the state register; scl_o and sda_o are tied low.
   // ************************************************************
   assign prdata_o = q.prdata;
   assign pready_o = q.pready;
   assign pslverr_o = q.pslverr;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = q.scl_oe;
   assign sda_oe_o = q.sda_oe;
   assign wake_o = q.wake;
   assign slave_transmit_mode_o = q.slave_tx;
   assign start_pending_o = q.start_pend;

endmodule : twi_slave_receiver

/* testbench/slave_rx_asserts.sv */
`timescale 1ns/1ps
// ************************************************************
// Port checks of the two-wire slave receiver.
// ************************************************************
module slave_rx_asserts (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Register port.
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Bus pins and neighbours.
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe_o,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic deep_sleep_i,
   input wire logic wake_o,
   input wire logic slave_transmit_mode_o
);
   // Accepted write of a one into the flag bit.
   logic clr;
   assign clr = psel_i & penable_i & pready_o & pwrite_i & pwdata_i[7]
      & (paddr_i == twi_sr_pkg::ADDR_CTRL);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Setup cycle, and a flag clear seen one to three cycles back.
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_clr;
      $past(clr) || $past(clr, 2) || $past(clr, 3);
   endsequence
   property p_ready;
      s_setup |=> pready_o && penable_i;
   endproperty
   property p_err;
      pslverr_o |-> pready_o && prdata_o == 32'h0;
   endproperty
   property p_upper;
      pready_o |-> prdata_o[31:8] == 24'h0;
   endproperty
   property p_drain;
      scl_o == 1'b0 && sda_o == 1'b0 && !(scl_oe_o && sda_oe_o);
   endproperty
   property p_release;
      $fell(scl_oe_o) |-> s_clr;
   endproperty
   property p_stretch;
      $rose(scl_oe_o) |-> !$past(scl_i);
   endproperty
   property p_ack;
      $changed(sda_oe_o) |-> !scl_i;
   endproperty
   property p_tx;
      slave_transmit_mode_o |-> !sda_oe_o;
   endproperty
   property p_wake;
      $rose(wake_o) |-> deep_sleep_i;
   endproperty
   property p_wake_end;
      $fell(wake_o) |-> s_clr;
   endproperty
   a_ready: assert property (p_ready)
      else $error("no ready in first access cycle");
   a_err: assert property (p_err)
      else $error("error answer carries data");
   a_upper: assert property (p_upper)
      else $error("upper read bits not zero");
   a_drain: assert property (p_drain)
      else $error("pin drives high or data held during stretch");
   a_release: assert property (p_release)
      else $error("clock released without flag clear");
   a_stretch: assert property (p_stretch)
      else $error("stretch begins while clock high");
   a_ack: assert property (p_ack)
      else $error("data line moved while clock high");
   a_tx: assert property (p_tx)
      else $error("acknowledge driven for read");
   a_wake: assert property (p_wake)
      else $error("wake outside deep sleep");
   a_wake_end: assert property (p_wake_end)
      else $error("wake fell without flag clear");
endmodule : slave_rx_asserts
bind twi_slave_receiver slave_rx_asserts u_slave_rx_asserts (
   .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .deep_sleep_i(deep_sleep_i), .wake_o(wake_o),
   .slave_transmit_mode_o(slave_transmit_mode_o));

/* testbench/bus_master_model.sv */
`timescale 1ns/1ps
// ************************************************************
// Behavioural two-wire master transmitter.
// ************************************************************
module bus_master_model (
   // Resolved bus lines.
   input wire logic scl_i,
   input wire logic sda_i,
   // High while the model pulls a line low.
   output logic scl_low_o = 1'b0,
   output logic sda_low_o = 1'b0
);
   // START: the data line falls while the clock is high.
   task automatic start();
      sda_low_o = 1'b1;
      #80ns;
      scl_low_o = 1'b1;
   endtask : start
   // One bit; the gap after the clock fall keeps data moves clear of
   // the high phase, and the wait honours a stretching slave.
   task automatic bit_io(input logic b, output logic s);
      #20ns;
      sda_low_o = !b;
      #60ns;
      scl_low_o = 1'b0;
      wait (scl_i === 1'b1);
      #80ns;
      s = sda_i;
      scl_low_o = 1'b1;
   endtask : bit_io
   // A byte MSB first, then the ninth clock for the answer.
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = !s;
   endtask : send_byte
   // STOP: the data line rises while the clock is high.
   task automatic stop();
      #20ns;
      sda_low_o = 1'b1;
      #60ns;
      scl_low_o = 1'b0;
      wait (scl_i === 1'b1);
      #80ns;
      sda_low_o = 1'b0;
      #80ns;
   endtask : stop
endmodule : bus_master_model

/* testbench/testbench.sv */
`timescale 1ns/1ps
// ************************************************************
// Self-checking bench of the two-wire slave receiver.
// ************************************************************
module testbench;
   // Stimulus, responses and counters.
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, arb_lost = 1'b0, deep_sleep = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, scl_oe, sda_oe, wake, tx_mode;
   logic m_scl, m_sda, last_err, st_pend;
   int fail_count = 0;
   int samples_checked = 0;
   // Open-drain lines with pull-ups.
   wire scl_w = !(m_scl | scl_oe);
   wire sda_w = !(m_sda | sda_oe);
   twi_slave_receiver u_twi_slave_receiver (
      .clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_w),
      .sda_o(), .sda_oe_o(sda_oe), .arb_lost_i(arb_lost),
      .deep_sleep_i(deep_sleep), .wake_o(wake),
      .slave_transmit_mode_o(tx_mode), .start_pending_o(st_pend));
   bus_master_model u_bus_master_model (.scl_i(scl_w), .sda_i(sda_w),
      .scl_low_o(m_scl), .sda_low_o(m_sda));
   // Clock of 4 ns.
   always #2 clk = ~clk;
   // Counts one comparison and reports a difference.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch at %0t: got %h, expected %h", $time, g, e);
      end
   endtask : chk
   // One APB transfer; it waits for ready without a count of its own.
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [7:0] d, output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      apb(1'b0, a, 8'h00, r);
      chk(r, {24'h0, e});
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask : wr
   task automatic wc(input logic [7:0] d);
      wr(twi_sr_pkg::ADDR_CTRL, d);
   endtask : wc
   // Waits for the clock stretch, then reads the masked status.
   task automatic hst(input logic [7:0] e);
      logic [31:0] r;
      for (int n = 0; n < 100 && scl_oe !== 1'b1; n++) @(posedge clk);
      chk(scl_oe, 1'b1);
      apb(1'b0, twi_sr_pkg::ADDR_STAT, 8'h00, r);
      chk(r[7:0] & twi_sr_pkg::PRESC_MASK, e);
   endtask : hst
   // A byte from the master and the answer it got.
   task automatic dat(input logic [7:0] d, input logic e);
      logic a;
      u_bus_master_model.send_byte(d, a);
      chk(a, e);
   endtask : dat
   task automatic adr(input logic [7:0] b, input logic e);
      u_bus_master_model.start();
      dat(b, e);
   endtask : adr
   // Releases any hold, ends the frame, clears the flag it raised.
   task automatic fin();
      wc(8'hC4);
      u_bus_master_model.stop();
      wc(8'hC4);
   endtask : fin
   task automatic t_regs();
      rd(twi_sr_pkg::ADDR_OWN, 8'h00);
      rd(twi_sr_pkg::ADDR_CTRL, 8'h00);
      rd(twi_sr_pkg::ADDR_STAT, 8'hF8);
      rd(8'h10, 8'h00);
      chk(last_err, 1'b1);
      wr(twi_sr_pkg::ADDR_OWN, 8'h55);
      rd(twi_sr_pkg::ADDR_OWN, 8'h55);
      wc(8'h40);
      adr(8'h54, 1'b0);
      fin();
      wc(8'h44);
      rd(twi_sr_pkg::ADDR_CTRL, 8'h44);
      adr(8'h55, 1'b0);
      chk(tx_mode, 1'b1);
      fin();
      chk(tx_mode, 1'b0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_own();
      adr(8'h54, 1'b1);
      hst(twi_sr_pkg::STS_OWN_W);
      wc(8'hC4);
      dat(8'hA5, 1'b1);
      hst(twi_sr_pkg::STS_DATA_ACK);
      rd(twi_sr_pkg::ADDR_DATA, 8'hA5);
      wc(8'h84);
      dat(8'h3C, 1'b0);
      hst(twi_sr_pkg::STS_DATA_NACK);
      wc(8'h84);
      u_bus_master_model.stop();
      adr(8'h54, 1'b0);
      u_bus_master_model.stop();
      wc(8'h44);
      adr(8'h54, 1'b1);
      hst(twi_sr_pkg::STS_OWN_W);
      wc(8'hC4);
      u_bus_master_model.stop();
      rd(twi_sr_pkg::ADDR_STAT, twi_sr_pkg::STS_STOP);
      wc(8'hC4);
      $display("test own done");
   endtask : t_own
   task automatic t_arb(input logic [7:0] b, input logic [7:0] e);
      @(posedge clk);
      arb_lost <= 1'b1;
      @(posedge clk);
      arb_lost <= 1'b0;
      adr(b, 1'b1);
      hst(e);
      fin();
      $display("test lost arbitration done");
   endtask : t_arb
   task automatic t_gc();
      adr(8'h00, 1'b1);
      hst(twi_sr_pkg::STS_GC);
      wc(8'hC4);
      dat(8'h11, 1'b1);
      hst(twi_sr_pkg::STS_GC_ACK);
      wc(8'h84);
      dat(8'h22, 1'b0);
      hst(twi_sr_pkg::STS_GC_NACK);
      fin();
      wr(twi_sr_pkg::ADDR_OWN, 8'h54);
      adr(8'h00, 1'b0);
      fin();
      wc(8'h64);
      @(posedge clk);
      chk(st_pend, 1'b1);
      wc(8'h44);
      $display("test general call done");
   endtask : t_gc
   task automatic t_sleep();
      @(posedge clk);
      deep_sleep <= 1'b1;
      adr(8'h54, 1'b1);
      hst(twi_sr_pkg::STS_OWN_W);
      chk(wake, 1'b1);
      repeat (50) @(posedge clk);
      chk(scl_oe, 1'b1);
      wc(8'hC4);
      repeat (3) @(posedge clk);
      chk(wake, 1'b0);
      chk(scl_oe, 1'b0);
      deep_sleep <= 1'b0;
      fin();
      $display("test sleep done");
   endtask : t_sleep
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   // Main sequence after five reset cycles.
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_own();
      t_arb(8'h54, twi_sr_pkg::STS_ARB_OWN_W);
      t_arb(8'h00, twi_sr_pkg::STS_ARB_GC);
      t_gc();
      t_sleep();
      stop_test();
   end
   // Watchdog well beyond the expected run of about 25 us.
   initial begin
      #200us;
      fail_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule : testbench
